//--- rtl/cpf_pkg.sv
/*
 Constants for the co-processor command ring front end.
 Assumes a byte-addressed register port with 16-bit addresses and 32-bit data.
*/
package cpf_pkg;
   // Ring geometry
   localparam int          RING_BYTES    = 4096;
   localparam int          RING_WORDS    = RING_BYTES / 4;
   localparam int          PTR_W         = 12;
   localparam int          IDX_W         = 10;
   localparam logic [11:0] PTR_STEP      = 12'h004;
   localparam logic [11:0] RING_USABLE   = 12'hFFC;
   localparam logic [11:0] PTR_RST       = 12'h000;
   // Display list memory
   localparam int          DL_W          = 11;
   localparam logic [10:0] DL_STEP       = 11'h001;
   localparam logic [10:0] DL_RST        = 11'h000;
   // Register port
   localparam int          ADDR_W        = 16;
   localparam logic [15:0] RING_BASE     = 16'h0000;
   localparam logic [15:0] RING_WINDOW   = 16'h2000;
   localparam logic [15:0] OFS_WR_PTR    = 16'h2000;
   localparam logic [15:0] OFS_RD_PTR    = 16'h2004;
   localparam logic [15:0] OFS_DL_OFFSET = 16'h2008;
   localparam logic [15:0] OFS_FREE      = 16'h200C;
   localparam logic [15:0] OFS_APPEND    = 16'h2010;
   localparam logic [15:0] OFS_INT_STS   = 16'h2014;
   localparam logic [15:0] OFS_INT_MASK  = 16'h2018;
   // Interrupt bits
   localparam int          INT_W         = 3;
   localparam int          INT_DRAINED   = 0;
   localparam int          INT_PTR_ERR   = 1;
   localparam int          INT_OVERFLOW  = 2;
   localparam logic [2:0]  INT_RST       = 3'h0;
   // Command words
   localparam logic [23:0] CMD_PREFIX    = 24'hFF_FFFF;
   localparam logic [7:0]  CMD_NEW_LIST  = 8'h00;
   localparam logic [7:0]  CMD_SKIP      = 8'h01;
   localparam logic [31:0] WORD_ROUND    = 32'h0000_0003;
   localparam logic [31:0] ZERO32        = 32'h0000_0000;

   typedef enum logic [0:0] {ENG_IDLE, ENG_EXEC} cpf_eng_e;
endpackage

//--- rtl/cpf_command_fifo.sv
/*
 Command ring, bulk append port and engine front end that copies raw
 display list words into display list memory.
 Assumes a single 100 MHz clock, a synchronous master on the register port
 and display list memory that takes one write per cycle without stall.
*/
// What this block does
// - 4 KB circular ring, host fills, engine drains
// - Host moves write pointer, engine moves read pointer
// - Equal pointers mean ring empty and done
// - Ring writes wrap from offset 4095 to 0
// - Word entries; unaligned pointer is an error
// - Trailing 1-3 bytes skipped to word boundary
// - Bulk port writes append and advance write pointer
// - Free space reads 4092 when ring empty
// - Display list words written at incrementing offset
// - New-list command clears display list offset
// - Raw display list words copied unchanged
// - Drained flag set when last command finishes
`timescale 1ns/1ps
module cpf_command_fifo
   import cpf_pkg::*;
(
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                srst,
   // Register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   // Display list memory write port
   output logic                     dl_wr,
   output logic      [DL_W-1:0]     dl_addr,
   output logic      [31:0]         dl_data,
   // Status
   output logic                     engine_busy,
   output logic                     irq
);

   logic [31:0]      ring [RING_WORDS];
   logic [31:0]      mem_q_r;

   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [DL_W-1:0]  dl_off_r, dl_off_nxt;
   cpf_eng_e         eng_r, eng_nxt;
   logic             len_pend_r, len_pend_nxt;
   logic [29:0]      skip_r, skip_nxt;
   logic             dl_wr_r, dl_wr_nxt;
   logic [DL_W-1:0]  dl_addr_r, dl_addr_nxt;
   logic [31:0]      dl_data_r, dl_data_nxt;
   logic [INT_W-1:0] sts_r, sts_nxt;
   logic [INT_W-1:0] mask_r, mask_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   logic             irq_r, irq_nxt;
   logic             busy_r, busy_nxt;

   logic [PTR_W-1:0] occupancy;
   logic [PTR_W-1:0] free_space;
   logic             ring_hit;
   logic             append_hit;
   logic             append_ok;
   logic             mem_we;
   logic [IDX_W-1:0] mem_widx;
   logic [INT_W-1:0] ev;
   logic             exec_go;
   logic             is_cmd;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = p + PTR_STEP;
   endfunction

   function automatic logic [IDX_W-1:0] ptr_idx(input logic [PTR_W-1:0] p);
      ptr_idx = p[PTR_W-1:2];
   endfunction

   // Ring occupancy never reaches 4096, so equal pointers are unambiguous
   assign occupancy  = wr_ptr_r - rd_ptr_r;
   assign free_space = RING_USABLE - occupancy;

   // The window is twice the ring, mirrored, so a burst that starts
   // inside the ring runs on past the top and lands at the bottom
   assign ring_hit   = reg_wr && (reg_addr < RING_WINDOW);
   assign append_hit = reg_wr && (reg_addr == OFS_APPEND);
   // Appends beyond the usable space are dropped and flagged
   assign append_ok  = append_hit && (free_space != PTR_RST);
   assign mem_we     = ring_hit || append_ok;
   assign mem_widx   = append_ok ? ptr_idx(wr_ptr_r) : reg_addr[PTR_W-1:2];

   // Ring storage: one write port for the host, one read port for the engine and a second read port for host reads
   always_ff @(posedge sys_clk)
   begin
      if (mem_we)
      begin
         ring[mem_widx] <= reg_wdata;
      end
      mem_q_r <= ring[ptr_idx(rd_ptr_r)];
   end

   assign exec_go = (eng_r == ENG_EXEC);
   assign is_cmd  = (mem_q_r[31:8] == CMD_PREFIX);

   // Engine and pointers
   always_comb
   begin
      eng_nxt      = eng_r;
      rd_ptr_nxt   = rd_ptr_r;
      wr_ptr_nxt   = wr_ptr_r;
      dl_off_nxt   = dl_off_r;
      len_pend_nxt = len_pend_r;
      skip_nxt     = skip_r;
      dl_wr_nxt    = 1'b0;
      dl_addr_nxt  = dl_addr_r;
      dl_data_nxt  = dl_data_r;
      ev           = INT_RST;
      if (reg_wr && (reg_addr == OFS_WR_PTR))
      begin
         if (reg_wdata[1:0] == 2'b00)
         begin
            wr_ptr_nxt = reg_wdata[PTR_W-1:0];
         end
         else
         begin
            ev[INT_PTR_ERR] = 1'b1;
         end
      end
      if (append_ok)
      begin
         wr_ptr_nxt = ptr_inc(wr_ptr_r);
      end
      if (append_hit && !append_ok)
      begin
         ev[INT_OVERFLOW] = 1'b1;
      end
      unique case (eng_r)
         ENG_IDLE:
         begin
            if (rd_ptr_r != wr_ptr_r)
            begin
               eng_nxt = ENG_EXEC;
            end
         end
         ENG_EXEC:
         begin
            eng_nxt    = ENG_IDLE;
            rd_ptr_nxt = ptr_inc(rd_ptr_r);
            if (skip_r != 30'h0)
            begin
               skip_nxt = skip_r - 30'h1;
            end
            else if (len_pend_r)
            begin
               len_pend_nxt = 1'b0;
               skip_nxt     = 30'((mem_q_r + WORD_ROUND) >> 2);
            end
            else if (is_cmd && mem_q_r[7:0] == CMD_NEW_LIST)
            begin
               dl_off_nxt = DL_RST;
            end
            else if (is_cmd && mem_q_r[7:0] == CMD_SKIP)
            begin
               len_pend_nxt = 1'b1;
            end
            else if (!is_cmd)
            begin
               dl_wr_nxt   = 1'b1;
               dl_addr_nxt = dl_off_r;
               dl_data_nxt = mem_q_r;
               dl_off_nxt  = dl_off_r + DL_STEP;
            end
            // Unknown co-processor commands are consumed as one word
            if (ptr_inc(rd_ptr_r) == wr_ptr_r && len_pend_nxt == 1'b0
                && skip_nxt == 30'h0)
            begin
               ev[INT_DRAINED] = 1'b1;
            end
         end
      endcase
   end

   // Interrupts and read data
   always_comb
   begin
      mask_nxt  = mask_r;
      sts_nxt   = sts_r;
      rdata_nxt = ZERO32;
      if (reg_wr && (reg_addr == OFS_INT_MASK))
      begin
         mask_nxt = reg_wdata[INT_W-1:0];
      end
      if (reg_wr && (reg_addr == OFS_INT_STS))
      begin
         sts_nxt = sts_r & ~reg_wdata[INT_W-1:0];
      end
      // Set beats clear in the same cycle
      sts_nxt  = sts_nxt | ev;
      irq_nxt  = |(sts_nxt & mask_nxt);
      busy_nxt = (rd_ptr_nxt != wr_ptr_nxt) || (eng_nxt == ENG_EXEC);
      if (reg_rd)
      begin
         if (reg_addr < RING_WINDOW)
         begin
            rdata_nxt = ring[reg_addr[PTR_W-1:2]];
         end
         else
         begin
            unique case (reg_addr)
               OFS_WR_PTR:    rdata_nxt = {20'h0_0000, wr_ptr_r};
               OFS_RD_PTR:    rdata_nxt = {20'h0_0000, rd_ptr_r};
               OFS_DL_OFFSET: rdata_nxt = {21'h00_0000, dl_off_r};
               OFS_FREE:      rdata_nxt = {20'h0_0000, free_space};
               OFS_INT_STS:   rdata_nxt = {29'h0000_0000, sts_r};
               OFS_INT_MASK:  rdata_nxt = {29'h0000_0000, mask_r};
               default:       rdata_nxt = ZERO32;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         eng_r      <= ENG_IDLE;
         wr_ptr_r   <= PTR_RST;
         rd_ptr_r   <= PTR_RST;
         dl_off_r   <= DL_RST;
         len_pend_r <= 1'b0;
         skip_r     <= 30'h0;
         dl_wr_r    <= 1'b0;
         dl_addr_r  <= DL_RST;
         dl_data_r  <= ZERO32;
         sts_r      <= INT_RST;
         mask_r     <= INT_RST;
         rdata_r    <= ZERO32;
         irq_r      <= 1'b0;
         busy_r     <= 1'b0;
      end
      else
      begin
         eng_r      <= eng_nxt;
         wr_ptr_r   <= wr_ptr_nxt;
         rd_ptr_r   <= rd_ptr_nxt;
         dl_off_r   <= dl_off_nxt;
         len_pend_r <= len_pend_nxt;
         skip_r     <= skip_nxt;
         dl_wr_r    <= dl_wr_nxt;
         dl_addr_r  <= dl_addr_nxt;
         dl_data_r  <= dl_data_nxt;
         sts_r      <= sts_nxt;
         mask_r     <= mask_nxt;
         rdata_r    <= rdata_nxt;
         irq_r      <= irq_nxt;
         busy_r     <= busy_nxt;
      end
   end

   assign reg_rdata   = rdata_r;
   assign dl_wr       = dl_wr_r;
   assign dl_addr     = dl_addr_r;
   assign dl_data     = dl_data_r;
   assign engine_busy = busy_r;
   assign irq         = irq_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   AST_EMPTY_HOLDS: assert property ((eng_r == ENG_IDLE && rd_ptr_r == wr_ptr_r)
      |=> $stable(rd_ptr_r))
      else $error("Read pointer moved on an empty ring");
   AST_FREE_EMPTY: assert property ((rd_ptr_r == wr_ptr_r) |-> free_space == 12'hFFC)
      else $error("Free space not 4092 on empty ring");
   AST_RD_STEP: assert property (exec_go |=> rd_ptr_r == $past(rd_ptr_r) + 12'h004)
      else $error("Read pointer did not step one word");
   AST_ALIGNED: assert property (rd_ptr_r[1:0] == 2'b00 && wr_ptr_r[1:0] == 2'b00)
      else $error("Ring pointer not word aligned");
   AST_DL_INC: assert property (dl_wr_r |-> dl_off_r == dl_addr_r + 11'h001)
      else $error("Display list offset did not follow write");
   AST_NEW_LIST: assert property ((exec_go && skip_r == 30'h0 && !len_pend_r && is_cmd
      && mem_q_r[7:0] == CMD_NEW_LIST) |=> dl_off_r == 11'h000 && !dl_wr_r)
      else $error("New list did not clear offset");
   AST_BULK_STEP: assert property (append_ok |=> wr_ptr_r == $past(wr_ptr_r) + 12'h004)
      else $error("Bulk append did not advance write pointer");
   AST_RAW_COPY: assert property ((exec_go && skip_r == 30'h0 && !len_pend_r && !is_cmd)
      |=> dl_wr_r && dl_data_r == $past(mem_q_r))
      else $error("Raw word not copied unchanged");
   AST_SKIP_QUIET: assert property ((exec_go && skip_r != 30'h0) |=> !dl_wr_r)
      else $error("Skipped data reached display list");
   AST_DRAINED: assert property ((exec_go && skip_r == 30'h0 && !len_pend_r && !is_cmd
      && rd_ptr_r + 12'h004 == wr_ptr_r) |=> sts_r[INT_DRAINED])
      else $error("Drained flag not raised");
   AST_RESET: assert property (disable iff (1'b0) srst |=>
      rd_ptr_r == 12'h000 && wr_ptr_r == 12'h000 && dl_off_r == 11'h000)
      else $error("Reset did not clear pointers");

endmodule // cpf_command_fifo

//--- testbench/cpf_host_model.sv
/*
 Host controller model: bus master on the register port that fills the ring.
 Assumes the device answers a read one cycle after the strobe and never stalls.
*/
`timescale 1ns/1ps
module cpf_host_model
   import cpf_pkg::*;
(
   // Clock
   input  wire logic              sys_clk,
   // Register port
   output logic      [ADDR_W-1:0] reg_addr,
   output logic      [31:0]       reg_wdata,
   output logic                   reg_wr,
   output logic                   reg_rd,
   input  wire logic [31:0]       reg_rdata,
   // Status
   input  wire logic              engine_busy
);
   logic [11:0] host_wr;

   initial
   begin
      reg_addr  = 16'h0000;
      reg_wdata = 32'h0000_0000;
      reg_wr    = 1'h0;
      reg_rd    = 1'h0;
      host_wr   = 12'h000;
   end

   // Released lines show the inverse of the last value, so a stale copy never matches
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'h0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'h0;
      reg_addr <= ~a;
      // Read data stand only in the cycle after the strobe; take them settled
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   // Never fill the ring completely, or it would read back as empty
   task automatic push(input logic [31:0] w);
      logic [31:0] r;
      logic [11:0] sp;
      int          n;
      n  = 0;
      sp = 12'h000;
      while (sp < PTR_STEP && n < 100)
      begin
         rd(OFS_RD_PTR, r);
         sp = RING_USABLE - (host_wr - r[11:0]);
         n++;
      end
      wr(RING_BASE + {4'h0, host_wr}, w);
      host_wr += PTR_STEP;
   endtask

   // Pointer moves only once the words are in place
   task automatic commit();
      wr(OFS_WR_PTR, {20'h0_0000, host_wr});
   endtask

   task automatic append(input logic [31:0] w);
      logic [31:0] f;
      rd(OFS_FREE, f);
      if (f > 32'h0000_0004)
      begin
         wr(OFS_APPEND, w);
         host_wr += PTR_STEP;
      end
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      repeat (2) @(posedge sys_clk);
      while (engine_busy !== 1'h0 && n < 200)
      begin
         @(posedge sys_clk);
         n++;
      end
   endtask
endmodule // cpf_host_model

//--- testbench/cpf_command_fifo_tb_top.sv
/*
 Self-checking bench for the command ring front end.
 Assumes the host model drives the register port and the list port never stalls.
*/
`timescale 1ns/1ps
module cpf_command_fifo_tb_top
   import cpf_pkg::*;
   ;
   logic              sys_clk = 1'h0;
   logic              srst    = 1'h1;
   wire logic [ADDR_W-1:0] reg_addr;
   wire logic [31:0]       reg_wdata;
   wire logic              reg_wr;
   wire logic              reg_rd;
   wire logic [31:0]       reg_rdata;
   wire logic              dl_wr;
   wire logic [DL_W-1:0]   dl_addr;
   wire logic [31:0]       dl_data;
   wire logic              engine_busy;
   wire logic              irq;
   logic [31:0]       v;
   logic [42:0]       dl_log[$];
   int                fail_count = 0;
   int                checked    = 0;
   int                cycles     = 0;
   logic [15:0]       row_addr[0:7] = '{OFS_WR_PTR, OFS_RD_PTR, OFS_DL_OFFSET, OFS_FREE,
                                        OFS_APPEND, OFS_INT_STS, OFS_INT_MASK, 16'h3000};
   logic [31:0]       row_exp[0:7]  = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                        32'h0000_0FFC, 32'h0000_0000, 32'h0000_0000,
                                        32'h0000_0000, 32'h0000_0000};

   always #5 sys_clk = ~sys_clk;

   cpf_command_fifo DUT (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dl_wr(dl_wr), .dl_addr(dl_addr), .dl_data(dl_data), .engine_busy(engine_busy),
      .irq(irq));

   cpf_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_busy(engine_busy));

   // Logged mid-cycle so an entry is queued before the edge that ends a wait
   always @(negedge sys_clk)
      if (dl_wr === 1'h1)
         dl_log.push_back({dl_addr, dl_data});

   task automatic give_verdict();
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [42:0] seen, input logic [42:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Ceiling well above the hundred-odd cycles the tests need
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (2) @(posedge sys_clk);
      srst <= 1'h0;
      for (int i = 0; i < 8; i++)
      begin
         host.rd(row_addr[i], v);
         check(v, row_exp[i]);
      end
      // Single raw word through the ring, drained interrupt unmasked
      host.wr(OFS_INT_MASK, 32'h0000_0007);
      host.push(32'h1234_5678);
      host.commit();
      host.wait_idle();
      check({42'h0, engine_busy}, 43'h000);
      check(dl_log.pop_front(), {11'h000, 32'h1234_5678});
      host.rd(OFS_RD_PTR, v);
      check(v, 32'h0000_0004);
      host.rd(OFS_FREE, v);
      check(v, 32'h0000_0FFC);
      check({42'h0, irq}, 43'h001);
      host.rd(OFS_INT_STS, v);
      check(v, 32'h0000_0001);
      host.wr(OFS_INT_STS, 32'h0000_0001);
      @(posedge sys_clk);
      check({42'h0, irq}, 43'h000);
      // Bulk append with a new list in mid-stream
      host.append(32'h0A0A_0001);
      host.append(32'h0A0A_0002);
      host.append(32'hFFFF_FF00);
      host.append(32'h0A0A_0003);
      host.wait_idle();
      check({42'h0, engine_busy}, 43'h000);
      check(dl_log.pop_front(), {11'h001, 32'h0A0A_0001});
      check(dl_log.pop_front(), {11'h002, 32'h0A0A_0002});
      check(dl_log.pop_front(), {11'h000, 32'h0A0A_0003});
      host.rd(OFS_WR_PTR, v);
      check(v, 32'h0000_0014);
      host.rd(OFS_RD_PTR, v);
      check(v, 32'h0000_0014);
      // Five data bytes, three pad bytes skipped
      host.append(32'hFFFF_FF01);
      host.append(32'h0000_0005);
      host.append(32'hDEAD_0001);
      host.append(32'hDEAD_0002);
      host.append(32'h0B0B_0001);
      host.wait_idle();
      check({42'h0, engine_busy}, 43'h000);
      check(dl_log.pop_front(), {11'h001, 32'h0B0B_0001});
      check(43'(dl_log.size()), 43'h000);
      host.rd(OFS_DL_OFFSET, v);
      check(v, 32'h0000_0002);
      // Ring window beyond the top folds back to the start
      host.wr(16'h1000, 32'h5A5A_0001);
      host.rd(RING_BASE, v);
      check(v, 32'h5A5A_0001);
      // Unaligned pointer refused and flagged
      host.wr(OFS_INT_STS, 32'h0000_0007);
      host.wr(OFS_WR_PTR, 32'h0000_0042);
      host.rd(OFS_WR_PTR, v);
      check(v, 32'h0000_0028);
      host.rd(OFS_INT_STS, v);
      check(v, 32'h0000_0002);
      check({42'h0, irq}, 43'h001);
      // Pointer set to the usable limit; the next append is refused and flagged
      host.rd(OFS_RD_PTR, v);
      host.wr(OFS_WR_PTR, v + 32'h0000_0FFC);
      host.wr(OFS_APPEND, 32'h0C0C_0001);
      host.rd(OFS_INT_STS, v);
      check(v, 32'h0000_0006);
      // Reset in mid-run while the engine still drains the full ring
      @(posedge sys_clk);
      srst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'h0;
      for (int i = 0; i < 8; i++)
      begin
         host.rd(row_addr[i], v);
         check(v, row_exp[i]);
      end
      check({41'h0, engine_busy, irq}, 43'h000);
      give_verdict();
   end
endmodule // cpf_command_fifo_tb_top
